// ==== pkg/fsrw_pkg.sv ====
// Constants, register map and state codes for the fault signal and reverse wakeup block.
// Assumes a 100 MHz clock; registers sit on AXI4-Lite at byte address = index * 4.
`default_nettype none

package fsrw_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned HB_PERIOD_MS = 400;
	localparam int unsigned HB_PERIOD_CYC = HB_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned GAP_LIMIT_US = 10;
	localparam int unsigned GAP_LIMIT_CYC = GAP_LIMIT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned VALID_WIN_US = 2000;
	localparam int unsigned VALID_WIN_CYC = VALID_WIN_US * (CLK_HZ / 1_000_000);
	localparam int unsigned HB_COUPLETS = 30;
	localparam int unsigned LISTEN_MIN_DEF = 31;

	// ************************************************************
	// Register indices
	// ************************************************************
	localparam logic [13:0] IDX_CHAIN_CTRL = 14'h0309;
	localparam logic [13:0] IDX_DIAG_CTRL = 14'h2000;
	localparam logic [13:0] IDX_DEV_CONF1 = 14'h2001;
	localparam logic [13:0] IDX_DEV_CONF2 = 14'h2002;
	localparam logic [13:0] IDX_FAULT_MASK = 14'h2020;
	localparam logic [13:0] IDX_FAULT_RST = 14'h2030;
	localparam logic [13:0] IDX_SUMMARY = 14'h2100;
	localparam logic [13:0] IDX_FAULT_REG = 14'h2101;
	localparam logic [13:0] IDX_FAULT_SYS = 14'h2102;
	localparam logic [13:0] IDX_FAULT_PWR = 14'h2103;
	localparam logic [13:0] IDX_FAULT_COMM1 = 14'h2104;
	localparam logic [13:0] IDX_DIAG_STAT = 14'h2110;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam logic [7:0] CONF1_RST = 8'h14;
	localparam int B_PULSE_TX_EN = 0;
	localparam int B_FPIN_EN = 2;
	localparam int B_TONE_RX_EN = 5;
	localparam int B_DISARM = 6;
	localparam int B_ARM = 7;
	localparam int B_DIR_SEL = 7;
	localparam int B_FORCE_WAKE = 0;
	localparam logic [1:0] WAKE_DIS_ALL = 2'h3;
	localparam int B_PWR = 0;
	localparam int B_SYS = 1;
	localparam int B_REG = 2;
	localparam int B_HB = 3;
	localparam int B_FTONE = 4;
	localparam int B_SUM_COMM = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// Listener state machine
	// ************************************************************
	typedef enum logic [2:0] {
		FSRW_RUN = 3'h1,
		FSRW_SHUT = 3'h2,
		FSRW_VALID = 3'h4
	} fsrw_state_e;

endpackage

`default_nettype wire

// ==== design/fsrw_core.sv ====
// Fault output, tone control, shutdown listener and latched wake output with register file.
// Assumes power-mode levels from the power controller and synchronous event pulses.
`default_nettype none

module fsrw_core
	import fsrw_pkg::*;
#(
	parameter int unsigned HB_PERIOD = HB_PERIOD_CYC,
	parameter int unsigned VALID_WIN = VALID_WIN_CYC,
	parameter int unsigned GAP_LIMIT = GAP_LIMIT_CYC,
	parameter int unsigned LISTEN_MIN = LISTEN_MIN_DEF
) (
	// Clock, resets, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic clk_en,
	// AXI4-Lite slave
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power mode from the device controller
	input wire logic mode_active,
	input wire logic mode_sleep,
	input wire logic mode_shutdown,
	// Fault events
	input wire logic frame_fault_hit,
	input wire logic rx_fault_tone,
	input wire logic rx_pulse_missing,
	input wire logic rx_pulse_fast,
	input wire logic always_on_switch_fail,
	input wire logic factory_check_error,
	input wire logic config_watch_error,
	// Supply monitors
	input wire logic core_overvoltage,
	input wire logic core_undervoltage,
	input wire logic converter_overvoltage,
	input wire logic converter_undervoltage,
	input wire logic reference_overvoltage,
	input wire logic reference_undervoltage,
	// Low-power listener front end
	input wire logic couplet_neg,
	// Tone transmitter requests
	input wire logic comm_tone_req,
	input wire logic [9:0] comm_tone_couplets,
	output logic tone_burst_start,
	output logic [9:0] tone_burst_couplets,
	output logic tone_burst_periodic,
	output logic tone_to_south,
	output logic tone_rx_enable,
	// Mode requests
	output logic validate_mode,
	output logic digital_reset_req,
	output logic shutdown_req,
	// Fault output, open drain
	output logic fault_out_n_o,
	output logic fault_out_n_oe,
	// Wake output pull-up
	input wire logic wake_pin_sense,
	output logic host_wake_out_o,
	output logic host_wake_out_oe
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0] conf1_q, wake_dis_q, fault_mask_reg_q, dir_q;
	logic [4:0] reg_flags_q, pwr_flags_q;
	logic [7:0] sys_flags_q, comm_flags_q;
	logic [3:0] summary;
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q, strb_q;
	logic [13:0] aw_idx_q;
	logic [7:0] wdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic wr_go, wr_hit, rd_hit, force_wake, wake_trig, wake_set, wake_dis;
	logic [7:0] rst_pulse, rd_val;
	logic host_wake_q, wake_flag_q, armed_q, shut_d1_q, level_seen_q, validate_seen_q;
	fsrw_state_e state_q;
	logic [7:0] cpl_cnt_q;
	logic [31:0] gap_q, win_q, hb_q;

	// Byte address to register index match
	function automatic logic idx_hit(input logic [15:0] a, input logic [13:0] idx);
		idx_hit = (a[15:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign s_axi_awready = clk_en && !aw_have_q && !bvalid_q;
	assign s_axi_wready = clk_en && !w_have_q && !bvalid_q;
	assign s_axi_arready = clk_en && !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign wr_go = aw_have_q && w_have_q;

	// Write decode
	always_comb begin
		wr_hit = 1'b0;
		rst_pulse = 8'h00;
		force_wake = 1'b0;
		case (aw_idx_q)
			IDX_CHAIN_CTRL, IDX_DEV_CONF1, IDX_DEV_CONF2, IDX_FAULT_MASK: wr_hit = 1'b1;
			IDX_DIAG_CTRL: begin
				wr_hit = 1'b1;
				force_wake = wr_go && strb_q && wdata_q[B_FORCE_WAKE];
			end
			IDX_FAULT_RST: begin
				wr_hit = 1'b1;
				rst_pulse = (wr_go && strb_q) ? wdata_q : 8'h00;
			end
			default: wr_hit = 1'b0;
		endcase
	end

	// Write address and data capture, response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_idx_q <= 14'h0000;
			wdata_q <= 8'h00;
			strb_q <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_idx_q <= (s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[15:2] : 14'h3fff;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				strb_q <= s_axi_wstrb[0]; // Unstrobed byte leaves registers alone
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conf1_q <= CONF1_RST;
			wake_dis_q <= 8'h00;
			fault_mask_reg_q <= 8'h00;
			dir_q <= 8'h00;
		end else if (clk_en && wr_go && strb_q) begin
			case (aw_idx_q)
				IDX_DEV_CONF1: conf1_q <= wdata_q;
				IDX_DEV_CONF2: wake_dis_q <= {6'h00, wdata_q[1:0]};
				IDX_FAULT_MASK: fault_mask_reg_q <= wdata_q;
				IDX_CHAIN_CTRL: dir_q <= {wdata_q[B_DIR_SEL], 7'h00};
				default: dir_q <= dir_q;
			endcase
		end
	end

	// Read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		case (s_axi_araddr[15:2])
			IDX_CHAIN_CTRL: rd_val = dir_q;
			IDX_DIAG_CTRL, IDX_FAULT_RST: rd_val = 8'h00;
			IDX_DEV_CONF1: rd_val = conf1_q;
			IDX_DEV_CONF2: rd_val = wake_dis_q;
			IDX_FAULT_MASK: rd_val = fault_mask_reg_q;
			IDX_SUMMARY: rd_val = {4'h0, summary};
			IDX_FAULT_REG: rd_val = {3'h0, reg_flags_q};
			IDX_FAULT_SYS: rd_val = sys_flags_q;
			IDX_FAULT_PWR: rd_val = {3'h0, pwr_flags_q};
			IDX_FAULT_COMM1: rd_val = comm_flags_q;
			IDX_DIAG_STAT: rd_val = {7'h00, level_seen_q};
			default: rd_hit = 1'b0;
		endcase
		if (s_axi_araddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end
	end

	// Read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Fault flags and roll-up
	// ************************************************************
	// Set wins over a reset-bit write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_flags_q <= 5'h00;
			comm_flags_q <= 8'h00;
			validate_seen_q <= 1'b0;
		end else if (clk_en) begin
			reg_flags_q[0] <= factory_check_error | (reg_flags_q[0] & ~rst_pulse[B_REG]);
			reg_flags_q[2] <= config_watch_error | (reg_flags_q[2] & ~rst_pulse[B_REG]);
			comm_flags_q[5] <= (mode_active & frame_fault_hit)
				| (tone_rx_enable & rx_fault_tone) | (comm_flags_q[5] & ~rst_pulse[B_FTONE]);
			comm_flags_q[4] <= (tone_rx_enable & rx_pulse_missing) | (comm_flags_q[4] & ~rst_pulse[B_HB]);
			comm_flags_q[3] <= (tone_rx_enable & rx_pulse_fast) | (comm_flags_q[3] & ~rst_pulse[B_HB]);
			validate_seen_q <= (state_q == FSRW_VALID) | (validate_seen_q & ~rst_pulse[B_SYS]);
		end
	end

	// Supply flags; the converter undervoltage flag must survive the reset it causes
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			pwr_flags_q <= 5'h00;
		end else if (clk_en) begin
			pwr_flags_q[0] <= always_on_switch_fail | (pwr_flags_q[0] & ~rst_pulse[B_PWR]);
			pwr_flags_q[1] <= reference_overvoltage | (pwr_flags_q[1] & ~rst_pulse[B_PWR]);
			pwr_flags_q[2] <= core_overvoltage | (pwr_flags_q[2] & ~rst_pulse[B_PWR]);
			pwr_flags_q[3] <= converter_overvoltage | (pwr_flags_q[3] & ~rst_pulse[B_PWR]);
			pwr_flags_q[4] <= converter_undervoltage | (pwr_flags_q[4] & ~rst_pulse[B_PWR]);
		end
	end

	// Supply actions
	assign digital_reset_req = core_undervoltage | converter_undervoltage;
	assign shutdown_req = reference_undervoltage;

	// Masked categories stay out of the roll-up
	assign summary[B_PWR] = |pwr_flags_q & ~fault_mask_reg_q[B_PWR];
	assign summary[B_SYS] = |sys_flags_q & ~fault_mask_reg_q[B_SYS];
	assign summary[B_REG] = |reg_flags_q & ~fault_mask_reg_q[B_REG];
	assign summary[B_SUM_COMM] = (comm_flags_q[5] & ~fault_mask_reg_q[B_FTONE])
		| (|comm_flags_q[4:3] & ~fault_mask_reg_q[B_HB]);

	// Open-drain fault output
	assign fault_out_n_o = 1'b0;
	assign fault_out_n_oe = conf1_q[B_FPIN_EN] && (summary != 4'h0);

	// ************************************************************
	// Listener and validate state machine
	// ************************************************************
	// Arming latched on shutdown entry, disarm first; cleared only from complete off or by a disarm at shutdown entry
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			armed_q <= 1'b0;
			shut_d1_q <= 1'b0;
		end else if (clk_en) begin
			shut_d1_q <= mode_shutdown;
			if (mode_shutdown && !shut_d1_q) begin
				armed_q <= conf1_q[B_DISARM] ? 1'b0 : (conf1_q[B_ARM] ? 1'b1 : armed_q);
			end
		end
	end

	// Couplet counter with gap timeout, shutdown only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpl_cnt_q <= 8'h00;
			gap_q <= 32'h0;
		end else if (clk_en) begin
			if (state_q != FSRW_SHUT || !armed_q) begin
				cpl_cnt_q <= 8'h00;
				gap_q <= 32'h0;
			end else if (couplet_neg) begin
				cpl_cnt_q <= (cpl_cnt_q == 8'hff) ? cpl_cnt_q : cpl_cnt_q + 8'h01;
				gap_q <= 32'h0;
			end else if (gap_q >= GAP_LIMIT) begin
				cpl_cnt_q <= 8'h00;
			end else begin
				gap_q <= gap_q + 32'h1;
			end
		end
	end

	// Run, shutdown and validate sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= FSRW_RUN;
			win_q <= 32'h0;
		end else if (clk_en) begin
			case (state_q)
				FSRW_RUN: if (mode_shutdown) begin
					state_q <= FSRW_SHUT;
				end
				FSRW_SHUT: begin
					win_q <= 32'h0;
					if (!mode_shutdown) begin
						state_q <= FSRW_RUN;
					end else if (32'(cpl_cnt_q) >= LISTEN_MIN) begin
						state_q <= FSRW_VALID;
					end
				end
				FSRW_VALID: begin
					win_q <= win_q + 32'h1;
					if (!mode_shutdown) begin
						state_q <= FSRW_RUN;
					end else if (win_q >= VALID_WIN - 1) begin
						state_q <= FSRW_SHUT;
					end
				end
				default: state_q <= FSRW_RUN;
			endcase
		end
	end

	assign validate_mode = (state_q == FSRW_VALID);
	assign tone_rx_enable = (mode_sleep && conf1_q[B_TONE_RX_EN]) || validate_mode;

	// ************************************************************
	// Tone transmit scheduling
	// ************************************************************
	// Heartbeat repeats in sleep; communication tone is a single burst
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hb_q <= 32'h0;
			tone_burst_start <= 1'b0;
			tone_burst_couplets <= 10'h000;
			tone_burst_periodic <= 1'b0;
		end else if (clk_en) begin
			tone_burst_start <= 1'b0;
			if (mode_sleep && conf1_q[B_PULSE_TX_EN]) begin
				hb_q <= (hb_q >= HB_PERIOD - 1) ? 32'h0 : hb_q + 32'h1;
				if (hb_q == 32'h0) begin
					tone_burst_start <= 1'b1;
					tone_burst_couplets <= 10'(HB_COUPLETS);
					tone_burst_periodic <= 1'b1;
				end
			end else begin
				hb_q <= 32'h0;
				if (comm_tone_req) begin
					tone_burst_start <= 1'b1;
					tone_burst_couplets <= comm_tone_couplets;
					tone_burst_periodic <= 1'b0;
				end
			end
		end
	end

	assign tone_to_south = dir_q[B_DIR_SEL];

	// ************************************************************
	// Wake output latch
	// ************************************************************
	assign wake_dis = (wake_dis_q[1:0] == WAKE_DIS_ALL);
	assign wake_trig = ((mode_sleep || validate_mode) && (comm_flags_q[5] || comm_flags_q[4]
		|| comm_flags_q[3] || pwr_flags_q[0] || reg_flags_q[0] || reg_flags_q[2]))
		|| (mode_active && force_wake);
	assign wake_set = wake_trig && !wake_dis;

	// Latch and flag survive digital reset
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			host_wake_q <= 1'b0;
			wake_flag_q <= 1'b0;
		end else if (clk_en) begin
			host_wake_q <= host_wake_q | wake_set;
			wake_flag_q <= wake_set | (wake_flag_q & ~(rst_pulse[B_SYS] & wake_dis));
		end
	end

	assign sys_flags_q = {validate_seen_q, 6'h00, wake_flag_q};

	// Pin level status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_seen_q <= 1'b0;
		end else if (clk_en) begin
			level_seen_q <= wake_pin_sense;
		end
	end

	assign host_wake_out_o = 1'b1;
	assign host_wake_out_oe = host_wake_q && !wake_dis;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !por_n);

	sequence s_force_write;
		clk_en && mode_active && force_wake && !wake_dis;
	endsequence
	sequence s_shut_trip;
		clk_en && state_q == FSRW_SHUT && mode_shutdown && 32'(cpl_cnt_q) >= LISTEN_MIN;
	endsequence

	a_fault_pin_off: assert property (!conf1_q[B_FPIN_EN] |-> !fault_out_n_oe)
		else $error("fault pin driven while disabled");
	a_fault_low_on: assert property (clk_en && conf1_q[B_FPIN_EN] && comm_flags_q[5]
		&& !fault_mask_reg_q[B_FTONE] |-> fault_out_n_oe)
		else $error("unmasked fault not on pin");
	a_masked_quiet: assert property (fault_mask_reg_q[B_PWR] |-> !summary[B_PWR])
		else $error("masked supply fault in roll-up");
	a_force_wake: assert property (s_force_write |=> host_wake_q && wake_flag_q)
		else $error("force write did not latch wake");
	a_wake_held: assert property (host_wake_q |=> host_wake_q)
		else $error("wake latch dropped");
	a_wake_disabled: assert property (wake_dis |-> !host_wake_out_oe)
		else $error("wake pin driven while disabled");
	a_shut_trip: assert property (s_shut_trip |=> validate_mode ##0 tone_rx_enable)
		else $error("listener trip did not validate");
	a_valid_entry: assert property ($rose(validate_mode) |-> $past(state_q) == FSRW_SHUT)
		else $error("validate entered outside shutdown");
	a_rx_gated: assert property (mode_sleep && !conf1_q[B_TONE_RX_EN] && !validate_mode
		|-> !tone_rx_enable)
		else $error("receiver on without enable");
	a_hb_gated: assert property (tone_burst_start && tone_burst_periodic
		|-> $past(mode_sleep && conf1_q[B_PULSE_TX_EN]))
		else $error("heartbeat burst without enable");

endmodule

`default_nettype wire

// ==== tb/fsrw_chain_model.sv ====
// Far-side model: stack couplet source, wake pin pull-down, fault pin pull-up.
// Assumes one clock; a burst starts on a one-cycle go pulse.
`default_nettype none
module fsrw_chain_model (
	// Clock and burst request
	input wire logic aclk,
	input wire logic burst_go,
	input wire logic [5:0] burst_len,
	input wire logic [4:0] burst_gap,
	// Design pins
	input wire logic wake_o,
	input wire logic wake_oe,
	input wire logic fault_o,
	input wire logic fault_oe,
	// Levels seen back
	output logic couplet_neg,
	output logic wake_pin_level,
	output logic fault_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] left_q = 6'h00;
	logic [4:0] tick_q = 5'h00;
	// Negative couplets only, burst_gap idle cycles apart
	always_ff @(posedge aclk) begin
		if (burst_go) begin
			left_q <= burst_len;
			tick_q <= 5'h00;
		end else if (left_q != 6'h00 && tick_q == 5'h00) begin
			left_q <= left_q - 6'h01;
			tick_q <= burst_gap;
		end else if (tick_q != 5'h00) begin
			tick_q <= tick_q - 5'h01;
		end
	end
	assign couplet_neg = (left_q != 6'h00) && (tick_q == 5'h00);
	// Released pins fall to their resistor levels
	assign wake_pin_level = wake_oe ? wake_o : 1'b0;
	assign fault_pin = fault_oe ? fault_o : 1'b1;
endmodule
`default_nettype wire

// ==== tb/test_fault_signal_reverse_wakeup.sv ====
// Bench for the fault signal and wakeup core: AXI4-Lite tasks and directed sequences.
// Assumes short timing parameters; the chain model supplies couplets and pin levels.
`default_nettype none
module test_fault_signal_reverse_wakeup;
	import fsrw_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, por_n = 0, s_axi_bready = 0, s_axi_rready = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, comm_tone_req = 0;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [12:0] ev = 0;
	logic [2:0] md = 3'h1;
	logic [9:0] comm_tone_couplets = 0, tone_burst_couplets, last_n;
	logic tone_burst_start, tone_burst_periodic, tone_to_south, tone_rx_enable, last_p;
	logic validate_mode, digital_reset_req, shutdown_req, fault_out_n_o, fault_out_n_oe;
	logic host_wake_out_o, host_wake_out_oe, wake_pin_sense, couplet_neg, fault_pin;
	logic burst_go = 0;
	logic clk_en = 1;
	logic [3:0] strb = 4'hf;
	logic [4:0] gap_v = 5'h02;
	logic [5:0] burst_len = 0;
	int mismatches = 0, checked = 0, starts = 0, s0 = 0;
	logic [3:0] trig [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h0};
	// Clock
	always #5 aclk = !aclk;
	// Design and far side
	fsrw_core #(.HB_PERIOD(20), .VALID_WIN(16), .GAP_LIMIT(8), .LISTEN_MIN(31)) dut (
		.aclk, .aresetn, .por_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(strb), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.mode_active(md[0]), .mode_sleep(md[1]), .mode_shutdown(md[2]),
		.frame_fault_hit(ev[7]), .rx_fault_tone(ev[8]), .rx_pulse_missing(ev[9]),
		.rx_pulse_fast(ev[10]), .always_on_switch_fail(ev[0]), .factory_check_error(ev[11]),
		.config_watch_error(ev[12]), .core_overvoltage(ev[2]), .core_undervoltage(ev[5]),
		.converter_overvoltage(ev[3]), .converter_undervoltage(ev[4]),
		.reference_overvoltage(ev[1]), .reference_undervoltage(ev[6]), .couplet_neg,
		.comm_tone_req, .comm_tone_couplets, .tone_burst_start, .tone_burst_couplets,
		.tone_burst_periodic, .tone_to_south, .tone_rx_enable, .validate_mode,
		.digital_reset_req, .shutdown_req, .fault_out_n_o, .fault_out_n_oe,
		.wake_pin_sense, .host_wake_out_o, .host_wake_out_oe);
	fsrw_chain_model chain (.aclk, .burst_go, .burst_len, .burst_gap(gap_v),
		.wake_o(host_wake_out_o), .wake_oe(host_wake_out_oe), .fault_o(fault_out_n_o),
		.fault_oe(fault_out_n_oe), .couplet_neg, .wake_pin_level(wake_pin_sense), .fault_pin);
	// Burst monitor
	always @(posedge aclk) begin
		if (tone_burst_start === 1'b1) begin
			starts <= starts + 1;
			last_n <= tone_burst_couplets;
			last_p <= tone_burst_periodic;
		end
	end
	// ****
	// Tasks
	// ****
	task summarize;
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rst(input logic p);
		aresetn <= 0;
		if (p) por_n <= 0;
		md <= 3'h1;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		por_n <= 1;
		@(posedge aclk);
	endtask
	task wr(input logic [13:0] i, input logic [7:0] d);
		logic b;
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		// Each channel drops at the edge that takes it; response taken at its edge
		do begin
			@(posedge aclk);
			b = s_axi_bvalid;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!b);
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task rd(input logic [13:0] i, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			d = s_axi_rdata;
			r = s_axi_rresp;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	task rc(input logic [13:0] i, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(i, d, r);
		chk(d, {24'h000000, e});
	endtask
	task pulse(input int i);
		ev <= 13'h0001 << i;
		@(posedge aclk);
		ev <= 13'h0000;
		repeat (3) @(posedge aclk);
	endtask
	task listen(input logic [5:0] n, input logic e);
		repeat (10) @(posedge aclk);
		burst_len <= n;
		burst_go <= 1;
		@(posedge aclk);
		burst_go <= 0;
		repeat (int'(n) * (int'(gap_v) + 1) + 3) @(posedge aclk);
		chk(validate_mode, e);
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		summarize();
	end
	// ****
	// Sequences
	// ****
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		rst(1);
		rc(IDX_DEV_CONF1, 8'h14);
		// Frozen clock enable must ignore a fault event
		clk_en <= 0;
		pulse(12);
		clk_en <= 1;
		rc(IDX_FAULT_REG, 8'h00);
		rd(14'h0001, d, r);
		chk(r, RESP_SLVERR);
		pulse(7);
		rc(IDX_FAULT_COMM1, 8'h20);
		wr(IDX_FAULT_MASK, 8'h11);
		pulse(0);
		rc(IDX_FAULT_PWR, 8'h01);
		rc(IDX_SUMMARY, 8'h00);
		chk(fault_pin, 1);
		chk(host_wake_out_oe, 0);
		wr(IDX_DEV_CONF1, 8'h10);
		// A write without the low byte strobe changes nothing
		strb <= 4'he;
		wr(IDX_FAULT_MASK, 8'h00);
		strb <= 4'hf;
		rc(IDX_FAULT_MASK, 8'h11);
		wr(IDX_FAULT_MASK, 8'h00);
		rc(IDX_SUMMARY, 8'h09);
		chk(fault_pin, 1);
		wr(IDX_DEV_CONF1, 8'h14);
		chk(fault_pin, 0);
		for (int i = 1; i < 5; i++) begin
			pulse(i);
			rc(IDX_FAULT_PWR, (8'h02 << i) - 8'h01);
		end
		for (int i = 5; i < 7; i++) begin
			ev <= 13'h0001 << i;
			@(negedge aclk);
			chk({digital_reset_req, shutdown_req}, (i == 5) ? 2'b10 : 2'b01);
			@(posedge aclk);
		end
		ev <= 13'h0000;
		wr(IDX_DIAG_CTRL, 8'h01);
		repeat (3) @(posedge aclk);
		chk(host_wake_out_oe, 1);
		rc(IDX_DIAG_STAT, 8'h01);
		rc(IDX_FAULT_SYS, 8'h01);
		rst(0);
		chk(host_wake_out_oe, 1);
		wr(IDX_DEV_CONF2, WAKE_DIS_ALL);
		chk(wake_pin_sense, 0);
		wr(IDX_FAULT_RST, 8'h02);
		rc(IDX_FAULT_SYS, 8'h00);
		rst(1);
		for (int k = 0; k < 2; k++) begin
			wr(IDX_CHAIN_CTRL, k ? 8'h00 : 8'h80);
			chk(tone_to_south, !k);
		end
		comm_tone_couplets <= 10'h05a;
		comm_tone_req <= 1;
		@(posedge aclk);
		comm_tone_req <= 0;
		repeat (3) @(posedge aclk);
		chk({last_p, last_n}, 11'h05a);
		wr(IDX_DEV_CONF1, 8'h15);
		s0 = starts;
		md <= 3'h2;
		repeat (50) @(posedge aclk);
		chk(starts - s0, 3);
		chk({last_p, last_n}, 11'h41e);
		md <= 3'h1;
		wr(IDX_DEV_CONF1, 8'h14);
		s0 = starts;
		md <= 3'h2;
		pulse(9);
		repeat (46) @(posedge aclk);
		chk(starts - s0, 0);
		chk(host_wake_out_oe, 0);
		rc(IDX_FAULT_COMM1, 8'h00);
		foreach (trig[t]) begin
			rst(1);
			wr(IDX_FAULT_MASK, 8'h1f);
			wr(IDX_DEV_CONF1, 8'h34);
			md <= 3'h2;
			pulse(trig[t]);
			chk(host_wake_out_oe, 1);
		end
		rst(1);
		md <= 3'h4;
		listen(31, 0);
		md <= 3'h1;
		wr(IDX_DEV_CONF1, 8'hd4);
		md <= 3'h4;
		listen(31, 0);
		md <= 3'h1;
		wr(IDX_DEV_CONF1, 8'h94);
		md <= 3'h4;
		listen(30, 0);
		gap_v <= 5'h09;
		listen(31, 0);
		gap_v <= 5'h02;
		listen(30, 0);
		listen(31, 1);
		chk(tone_rx_enable, 1);
		pulse(8);
		chk(host_wake_out_oe, 1);
		summarize();
	end
endmodule
`default_nettype wire
